// ---- verilog/pocb_pkg.sv ----
// Purpose: constants, types and register map of the preset and output command block
// Assumes: one 100 MHz clock, registers reached over a 16-bit register port
// Notes: 32-bit values span two registers, high word at the lower address
//
// Function
// [R1] code 41353 selects the regrease and rack-in timer preset command
// [R2] client writes parameter byte count 18 for the timer preset command
// [R3] client writes security type 1 for every command of this block
// [R4] password must equal the administrator or operator password, else refused
// [R5] regrease counter loads from parameter words one and two, 0 to 157766400
// [R6] an all-ones timer parameter leaves that timer unchanged
// [R7] rack-in counter loads from the third and fourth parameter words, 0 to 28944000
// [R8] code 42120 with byte count 13 acts on the light output
// [R9] code 42376 with byte count 13 acts on the load output
// [R10] light and load commands carry destination 8193 for the first io module
// [R11] bit 0 of parameter word one high byte sets output on or off
// [R12] bit 1 of that byte applies the state after a delay, else at once
// [R13] delay is 1 to 54000 seconds, split over two bytes, trailing byte zero
// [R14] with the delay bit clear the split delay field is ignored
// [R15] light state and pending delay are readable in light status registers
// [R16] load state and pending delay are readable in load status registers
// [R17] any mismatch rejects the command and leaves timers and outputs unchanged
package pocb_pkg;
   // command register addresses
   localparam logic [15:0] POCB_ADDR_CODE = 16'h1f3f;
   localparam logic [15:0] POCB_ADDR_COUNT = 16'h1f40;
   localparam logic [15:0] POCB_ADDR_DEST = 16'h1f41;
   localparam logic [15:0] POCB_ADDR_SECURITY = 16'h1f42;
   localparam logic [15:0] POCB_ADDR_PASS_HI = 16'h1f43;
   localparam logic [15:0] POCB_ADDR_PASS_LO = 16'h1f44;
   localparam logic [15:0] POCB_ADDR_PARAM_ONE = 16'h1f45;
   localparam logic [15:0] POCB_ADDR_PARAM_TWO = 16'h1f46;
   localparam logic [15:0] POCB_ADDR_RACK_HI = 16'h1f47;
   localparam logic [15:0] POCB_ADDR_RACK_LO = 16'h1f48;
   localparam int POCB_CMD_WORDS = 10;
   // status register addresses
   localparam logic [15:0] POCB_ADDR_RESULT = 16'h2100;
   localparam logic [15:0] POCB_ADDR_LIGHT_STATUS = 16'h2101;
   localparam logic [15:0] POCB_ADDR_LIGHT_REMAIN = 16'h2102;
   localparam logic [15:0] POCB_ADDR_LOAD_STATUS = 16'h2103;
   localparam logic [15:0] POCB_ADDR_LOAD_REMAIN = 16'h2104;
   localparam logic [15:0] POCB_ADDR_REGREASE_HI = 16'h2105;
   localparam logic [15:0] POCB_ADDR_REGREASE_LO = 16'h2106;
   localparam logic [15:0] POCB_ADDR_RACKTIME_HI = 16'h2107;
   localparam logic [15:0] POCB_ADDR_RACKTIME_LO = 16'h2108;
   // command values
   localparam logic [15:0] POCB_CODE_PRESET = 16'ha189;
   localparam logic [15:0] POCB_CODE_LIGHT = 16'ha488;
   localparam logic [15:0] POCB_CODE_LOAD = 16'ha588;
   localparam logic [15:0] POCB_COUNT_PRESET = 16'h0012;
   localparam logic [15:0] POCB_COUNT_OUTPUT = 16'h000d;
   localparam logic [15:0] POCB_SECURITY_TYPE = 16'h0001;
   localparam logic [15:0] POCB_DEST_IO_ONE = 16'h2001;
   localparam logic [31:0] POCB_NO_PRESET = 32'hffff_ffff;
   localparam logic [31:0] POCB_REGREASE_MAX = 32'h0967_5300;
   localparam logic [31:0] POCB_RACK_MAX = 32'h01b9_a680;
   localparam logic [15:0] POCB_DELAY_MIN = 16'h0001;
   localparam logic [15:0] POCB_DELAY_MAX = 16'hd2f0;
   localparam logic [7:0] POCB_UNUSED_BYTE = 8'h00;
   // bit positions inside parameter word one
   localparam int POCB_BIT_STATE = 8;
   localparam int POCB_BIT_DELAY = 9;
   // status register fields
   localparam int POCB_STAT_ON = 0;
   localparam int POCB_STAT_PENDING = 1;
   localparam int POCB_STAT_TARGET = 2;
   // timing
   localparam int POCB_SECOND_NS = 1_000_000_000;
   localparam int POCB_CLK_PERIOD_NS = 10;
   localparam int POCB_CYCLES_PER_SECOND = POCB_SECOND_NS / POCB_CLK_PERIOD_NS;
   localparam int POCB_PRESCALE_W = 27;

   typedef enum logic [1:0] {
      POCB_RES_NONE,
      POCB_RES_DONE,
      POCB_RES_REJECTED
   } pocb_result_t;

   typedef struct packed {
      logic [15:0] code;
      logic [15:0] count;
      logic [15:0] dest;
      logic [15:0] security;
      logic [31:0] password;
      logic [15:0] param_one;
      logic [15:0] param_two;
      logic [31:0] rack;
   } pocb_cmd_t;

   typedef struct packed {
      logic on;
      logic pending;
      logic target;
      logic [15:0] remaining;
   } pocb_out_status_t;
endpackage

// ---- verilog/pocb_out_timer.sv ----
// Purpose: one switched output with an optional delay counted in seconds
// Assumes: sec_tick is a one-cycle pulse once per second
// Notes: a new start replaces any delay still pending
`timescale 1ns/1ps
module pocb_out_timer
   import pocb_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // request
   input wire logic start,
   input wire logic target_state,
   input wire logic use_delay,
   input wire logic [15:0] delay_s,
   input wire logic sec_tick,
   // state
   output pocb_out_status_t status
);
   wire logic last_second = status.pending && sec_tick && (status.remaining == POCB_DELAY_MIN);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         status <= '0;
      end else if (start && use_delay) begin
         status.pending <= 1'b1; // R12
         status.target <= target_state;
         status.remaining <= delay_s; // R13
      end else if (start) begin
         status.on <= target_state; // R11
         status.pending <= 1'b0;
         status.remaining <= '0;
      end else if (last_second) begin
         status.on <= status.target;
         status.pending <= 1'b0;
         status.remaining <= '0;
      end else if (status.pending && sec_tick) begin
         status.remaining <= status.remaining - POCB_DELAY_MIN;
      end
   end

   property p_immediate;
      @(posedge clk) disable iff (!reset_n)
      start && !use_delay |=> status.on == $past(target_state) && !status.pending;
   endproperty
   a_immediate: assert property (p_immediate) else $error("immediate state not applied"); // R12

   property p_hold_while_pending;
      @(posedge clk) disable iff (!reset_n)
      status.pending && !start && !last_second |=> $stable(status.on);
   endproperty
   a_hold_while_pending: assert property (p_hold_while_pending) else $error("output moved early"); // R12

   property p_delay_expiry;
      @(posedge clk) disable iff (!reset_n)
      last_second && !start |=> status.on == $past(status.target) && !status.pending;
   endproperty
   a_delay_expiry: assert property (p_delay_expiry) else $error("delayed state not applied"); // R13
endmodule

// ---- verilog/pocb_command_block.sv ----
// Purpose: command register interpreter for timer preset, light and load commands
// Assumes: register port and trigger come from logic on the same clock
// Notes: a command runs when block_done pulses after the client wrote the block
`timescale 1ns/1ps
module pocb_command_block
   import pocb_pkg::*;
#(
   parameter int CYCLES_PER_SECOND = POCB_CYCLES_PER_SECOND
)
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire logic block_done,
   // credentials
   input wire logic [31:0] admin_password,
   input wire logic [31:0] operator_password,
   // breaker state pin
   input wire logic breaker_closed,
   // results
   output logic cmd_done,
   output pocb_result_t cmd_result,
   output logic light_on,
   output logic load_on,
   output logic [31:0] regrease_time,
   output logic [31:0] rack_in_time
);
   localparam logic [POCB_PRESCALE_W-1:0] PRESCALE_LAST =
      POCB_PRESCALE_W'(CYCLES_PER_SECOND - 1);

   logic [15:0] cmd_words [POCB_CMD_WORDS];
   logic [POCB_PRESCALE_W-1:0] prescale;
   logic sec_tick;
   logic [2:0] closed_sync;
   logic closed;
   pocb_out_status_t light_st;
   pocb_out_status_t load_st;

   // register write decode
   wire logic cmd_hit = reg_wr && (reg_addr >= POCB_ADDR_CODE) &&
      (reg_addr <= POCB_ADDR_RACK_LO);
   wire logic [15:0] cmd_offset = reg_addr - POCB_ADDR_CODE;
   wire logic [3:0] cmd_index = cmd_offset[3:0];

   // command block as one struct, high word first
   pocb_cmd_t cmd;
   assign cmd.code = cmd_words[0];
   assign cmd.count = cmd_words[1];
   assign cmd.dest = cmd_words[2];
   assign cmd.security = cmd_words[3];
   assign cmd.password = {cmd_words[4], cmd_words[5]};
   assign cmd.param_one = cmd_words[6];
   assign cmd.param_two = cmd_words[7];
   assign cmd.rack = {cmd_words[8], cmd_words[9]};

   // common checks
   wire logic pass_ok = (cmd.password == admin_password) ||
                        (cmd.password == operator_password); // R4
   wire logic security_ok = (cmd.security == POCB_SECURITY_TYPE); // R3
   wire logic common_ok = pass_ok && security_ok; // R17

   // timer preset checks
   wire logic is_preset = (cmd.code == POCB_CODE_PRESET) &&
                          (cmd.count == POCB_COUNT_PRESET); // R1 R2
   wire logic [31:0] regrease_val = {cmd.param_one, cmd.param_two}; // R5
   wire logic regrease_keep = (regrease_val == POCB_NO_PRESET); // R6
   wire logic regrease_ok = regrease_keep || (regrease_val <= POCB_REGREASE_MAX); // R5
   wire logic rack_keep = (cmd.rack == POCB_NO_PRESET); // R6
   wire logic rack_ok = rack_keep || (cmd.rack <= POCB_RACK_MAX); // R7
   wire logic accept_preset = is_preset && common_ok && regrease_ok && rack_ok;

   // output command checks
   wire logic dest_ok = (cmd.dest == POCB_DEST_IO_ONE); // R10
   wire logic output_count_ok = (cmd.count == POCB_COUNT_OUTPUT);
   wire logic is_light = (cmd.code == POCB_CODE_LIGHT) && output_count_ok; // R8
   wire logic is_load = (cmd.code == POCB_CODE_LOAD) && output_count_ok; // R9
   wire logic req_state = cmd.param_one[POCB_BIT_STATE]; // R11
   wire logic req_delay = cmd.param_one[POCB_BIT_DELAY]; // R12
   wire logic [15:0] delay_s = {cmd.param_one[7:0], cmd.param_two[15:8]}; // R13
   wire logic delay_ok = !req_delay ||
                         ((delay_s >= POCB_DELAY_MIN) && (delay_s <= POCB_DELAY_MAX) &&
                          (cmd.param_two[7:0] == POCB_UNUSED_BYTE)); // R13 R14
   wire logic output_ok = common_ok && dest_ok && delay_ok;
   wire logic accept_light = is_light && output_ok; // R8
   wire logic accept_load = is_load && output_ok; // R9
   wire logic accept_any = accept_preset || accept_light || accept_load;

   // execution strobes
   // a half-written block runs as it stands
   wire logic go = block_done;
   wire logic load_regrease = go && accept_preset && !regrease_keep; // R5 R6
   wire logic load_rack = go && accept_preset && !rack_keep; // R7 R6
   wire logic start_light = go && accept_light;
   wire logic start_load = go && accept_load;
   // ticks run free, so a delay may end up to one second early
   wire logic tick_last = (prescale == PRESCALE_LAST);
   // counters stop one short of all ones so they never read as the no-preset value
   wire logic regrease_run = sec_tick && closed &&
      (regrease_time != POCB_NO_PRESET - 32'h1);
   wire logic rack_run = sec_tick && (rack_in_time != POCB_NO_PRESET - 32'h1);
   wire pocb_result_t next_result = accept_any ? POCB_RES_DONE : POCB_RES_REJECTED; // R17

   // status read decode, write-only command registers read as zero
   wire logic [15:0] light_word = {13'h0000, light_st.target, light_st.pending, light_st.on};
   wire logic [15:0] load_word = {13'h0000, load_st.target, load_st.pending, load_st.on};
   wire logic [15:0] read_value =
      (reg_addr == POCB_ADDR_RESULT) ? {14'h0000, cmd_result} :
      (reg_addr == POCB_ADDR_LIGHT_STATUS) ? light_word : // R15
      (reg_addr == POCB_ADDR_LIGHT_REMAIN) ? light_st.remaining : // R15
      (reg_addr == POCB_ADDR_LOAD_STATUS) ? load_word : // R16
      (reg_addr == POCB_ADDR_LOAD_REMAIN) ? load_st.remaining : // R16
      (reg_addr == POCB_ADDR_REGREASE_HI) ? regrease_time[31:16] :
      (reg_addr == POCB_ADDR_REGREASE_LO) ? regrease_time[15:0] :
      (reg_addr == POCB_ADDR_RACKTIME_HI) ? rack_in_time[31:16] :
      (reg_addr == POCB_ADDR_RACKTIME_LO) ? rack_in_time[15:0] :
      16'h0000;

   // command registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int i = 0; i < POCB_CMD_WORDS; i++) begin
            cmd_words[i] <= 16'h0000;
         end
      end else if (cmd_hit) begin
         cmd_words[cmd_index] <= reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= read_value;
      end
   end

   // one-second prescaler
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         prescale <= '0;
         sec_tick <= 1'b0;
      end else begin
         prescale <= tick_last ? '0 : prescale + POCB_PRESCALE_W'(1);
         sec_tick <= tick_last;
      end
   end

   // breaker pin: three stages, a change counts once stages two and three agree
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         closed_sync <= 3'h0;
         closed <= 1'b0;
      end else begin
         closed_sync <= {closed_sync[1:0], breaker_closed};
         if (closed_sync[1] == closed_sync[2]) begin
            closed <= closed_sync[2];
         end
      end
   end

   // maintenance timers; a preset wins over the second tick of the same cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         regrease_time <= 32'h0000_0000;
      end else if (load_regrease) begin
         regrease_time <= regrease_val; // R5
      end else if (regrease_run) begin
         regrease_time <= regrease_time + 32'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rack_in_time <= 32'h0000_0000;
      end else if (load_rack) begin
         rack_in_time <= cmd.rack; // R7
      end else if (rack_run) begin
         rack_in_time <= rack_in_time + 32'h1;
      end
   end

   // command outcome
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cmd_done <= 1'b0;
         cmd_result <= POCB_RES_NONE;
      end else begin
         cmd_done <= go;
         if (go) begin
            cmd_result <= next_result; // R17
         end
      end
   end

   pocb_out_timer u_light (
      .clk(clk),
      .reset_n(reset_n),
      .start(start_light),
      .target_state(req_state),
      .use_delay(req_delay),
      .delay_s(delay_s),
      .sec_tick(sec_tick),
      .status(light_st)
   );

   pocb_out_timer u_load (
      .clk(clk),
      .reset_n(reset_n),
      .start(start_load),
      .target_state(req_state),
      .use_delay(req_delay),
      .delay_s(delay_s),
      .sec_tick(sec_tick),
      .status(load_st)
   );

   assign light_on = light_st.on;
   assign load_on = load_st.on;

   // checks
   sequence s_light_delayed;
      go && accept_light && req_delay;
   endsequence

   sequence s_load_now;
      go && accept_load && !req_delay;
   endsequence

   sequence s_light_now;
      go && accept_light && !req_delay;
   endsequence

   property p_preset_code;
      @(posedge clk) disable iff (!reset_n)
      go && accept_preset && !regrease_keep
      |=> regrease_time == $past(regrease_val);
   endproperty
   a_preset_code: assert property (p_preset_code) else $error("regrease preset not loaded"); // R1

   property p_regrease_range;
      @(posedge clk) disable iff (!reset_n)
      go && is_preset && (regrease_val > POCB_REGREASE_MAX) && !regrease_keep
      |=> cmd_result == POCB_RES_REJECTED;
   endproperty
   a_regrease_range: assert property (p_regrease_range) else $error("bad regrease taken"); // R5

   property p_no_preset;
      @(posedge clk) disable iff (!reset_n)
      go && accept_preset && regrease_keep && rack_keep && !sec_tick
      |=> $stable(regrease_time) && $stable(rack_in_time);
   endproperty
   a_no_preset: assert property (p_no_preset) else $error("timer changed on no-preset"); // R6

   property p_rack_load;
      @(posedge clk) disable iff (!reset_n)
      go && accept_preset && !rack_keep
      |=> rack_in_time == $past(cmd.rack);
   endproperty
   a_rack_load: assert property (p_rack_load) else $error("rack-in preset not loaded"); // R7

   property p_password;
      @(posedge clk) disable iff (!reset_n)
      go && !pass_ok
      |=> cmd_result == POCB_RES_REJECTED && cmd_done;
   endproperty
   a_password: assert property (p_password) else $error("bad password accepted"); // R4

   property p_light_delayed;
      @(posedge clk) disable iff (!reset_n)
      s_light_delayed
      |=> light_st.pending && $stable(light_on);
   endproperty
   a_light_delayed: assert property (p_light_delayed) else $error("light delay not armed"); // R12

   property p_load_now;
      @(posedge clk) disable iff (!reset_n)
      s_load_now
      |=> load_on == $past(req_state) && cmd_result == POCB_RES_DONE;
   endproperty
   a_load_now: assert property (p_load_now) else $error("load not switched"); // R9

   property p_delay_range;
      @(posedge clk) disable iff (!reset_n)
      go && is_light && req_delay && (delay_s > POCB_DELAY_MAX)
      |=> cmd_result == POCB_RES_REJECTED && $stable(light_st.pending);
   endproperty
   a_delay_range: assert property (p_delay_range) else $error("bad delay accepted"); // R13

   property p_reject_keeps;
      @(posedge clk) disable iff (!reset_n)
      go && !accept_any && !sec_tick
      |=> $stable(regrease_time) && $stable(rack_in_time) &&
          $stable(light_on) && $stable(load_on);
   endproperty
   a_reject_keeps: assert property (p_reject_keeps) else $error("rejected command acted"); // R17

   property p_dest;
      @(posedge clk) disable iff (!reset_n)
      go && (is_light || is_load) && !dest_ok
      |=> cmd_result == POCB_RES_REJECTED;
   endproperty
   a_dest: assert property (p_dest) else $error("wrong destination accepted"); // R10

   property p_light_status;
      @(posedge clk) disable iff (!reset_n)
      reg_rd && (reg_addr == POCB_ADDR_LIGHT_STATUS)
      |=> reg_rdata[POCB_STAT_ON] == $past(light_st.on) &&
          reg_rdata[POCB_STAT_PENDING] == $past(light_st.pending);
   endproperty
   a_light_status: assert property (p_light_status) else $error("light status wrong"); // R15

   property p_load_status;
      @(posedge clk) disable iff (!reset_n)
      reg_rd && (reg_addr == POCB_ADDR_LOAD_REMAIN)
      |=> reg_rdata == $past(load_st.remaining);
   endproperty
   a_load_status: assert property (p_load_status) else $error("load status wrong"); // R16

   property p_tick_single;
      @(posedge clk) disable iff (!reset_n)
      sec_tick |=> !sec_tick;
   endproperty
   a_tick_single: assert property (p_tick_single) else $error("second tick too long");

   property p_light_now;
      @(posedge clk) disable iff (!reset_n)
      s_light_now
      |=> light_on == $past(req_state) && cmd_result == POCB_RES_DONE;
   endproperty
   a_light_now: assert property (p_light_now) else $error("light not switched"); // R8

   property p_rack_range;
      @(posedge clk) disable iff (!reset_n)
      go && is_preset && (cmd.rack > POCB_RACK_MAX) && !rack_keep
      |=> cmd_result == POCB_RES_REJECTED;
   endproperty
   a_rack_range: assert property (p_rack_range) else $error("bad rack-in taken"); // R7

   property p_tail;
      @(posedge clk) disable iff (!reset_n)
      go && (is_light || is_load) && req_delay && (cmd.param_two[7:0] != POCB_UNUSED_BYTE)
      |=> cmd_result == POCB_RES_REJECTED;
   endproperty
   a_tail: assert property (p_tail) else $error("nonzero tail accepted"); // R13
endmodule

// ---- tb/pocb_client_model.sv ----
// Purpose: remote client that writes the command block and reads status registers
// Assumes: the design samples on the rising edge, so this model drives on the falling edge
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ps
module pocb_client_model
   import pocb_pkg::*;
(
   // clock
   input wire logic clk,
   // register port
   output logic reg_wr,
   output logic reg_rd,
   output logic [15:0] reg_addr,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   output logic block_done
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
      block_done = 1'b0;
   end
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
   // 32-bit values go high word first, at the lower address
   task automatic run(input pocb_cmd_t c);
      wr(POCB_ADDR_CODE, c.code);
      wr(POCB_ADDR_COUNT, c.count);
      wr(POCB_ADDR_DEST, c.dest);
      wr(POCB_ADDR_SECURITY, c.security);
      wr(POCB_ADDR_PASS_HI, c.password[31:16]);
      wr(POCB_ADDR_PASS_LO, c.password[15:0]);
      wr(POCB_ADDR_PARAM_ONE, c.param_one);
      wr(POCB_ADDR_PARAM_TWO, c.param_two);
      wr(POCB_ADDR_RACK_HI, c.rack[31:16]);
      wr(POCB_ADDR_RACK_LO, c.rack[15:0]);
      @(negedge clk);
      block_done = 1'b1;
      @(negedge clk);
      block_done = 1'b0;
   endtask
endmodule

// ---- tb/pocb_command_block_bench.sv ----
// Purpose: self-checking bench of the command block against a result model
// Assumes: a short second so that delays finish within the run
// Notes: breaker closes only in the last test; until then regrease moves only by presets
`timescale 1ns/1ps
module pocb_command_block_bench;
   import pocb_pkg::*;
   localparam int CPS = 10;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic breaker_closed = 1'b0;
   logic [31:0] admin_pw = 32'h0;
   logic [31:0] oper_pw = 32'h0;
   logic reg_wr, reg_rd, block_done, cmd_done, light_on, load_on;
   logic [15:0] reg_addr, reg_wdata, reg_rdata;
   pocb_result_t cmd_result;
   logic [31:0] regrease_time, rack_in_time;
   logic [31:0] seed = 32'd91000;
   int miscompares = 0;
   int check_count = 0;
   int exp_light = 0;
   int exp_load = 0;
   always #5 clk = ~clk;
   pocb_command_block #(.CYCLES_PER_SECOND(CPS)) i_dut (.clk(clk), .reset_n(reset_n),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .block_done(block_done), .admin_password(admin_pw),
      .operator_password(oper_pw), .breaker_closed(breaker_closed), .cmd_done(cmd_done),
      .cmd_result(cmd_result), .light_on(light_on), .load_on(load_on),
      .regrease_time(regrease_time), .rack_in_time(rack_in_time));
   pocb_client_model i_client (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .block_done(block_done));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   function automatic pocb_cmd_t mk(input logic [15:0] code, input logic [15:0] count,
      input logic [15:0] dest, input logic [31:0] pw, input logic [15:0] p1,
      input logic [15:0] p2, input logic [31:0] rk);
      return '{code, count, dest, 16'h0001, pw, p1, p2, rk};
   endfunction
   // result model: 1 done, 2 rejected
   function automatic int model(input pocb_cmd_t c);
      logic [15:0] dly;
      logic [31:0] rg;
      dly = {c.param_one[7:0], c.param_two[15:8]};
      rg = {c.param_one, c.param_two};
      if (c.security != 16'd1 || (c.password != admin_pw && c.password != oper_pw))
         return 2;
      if (c.code == 16'd41353 && c.count == 16'd18)
         return ((rg > 32'd157766400 && rg != '1) || (c.rack > 32'd28944000 && c.rack != '1))
            ? 2 : 1;
      if ((c.code == 16'd42120 || c.code == 16'd42376) && c.count == 16'd13
         && c.dest == 16'd8193)
         return (c.param_one[9] && (dly < 1 || dly > 54000 || c.param_two[7:0] != 0))
            ? 2 : 1;
      return 2;
   endfunction
   task automatic cmd(input pocb_cmd_t c, input string name);
      int res;
      logic [31:0] rg0, rk0, rg;
      res = model(c);
      rg = {c.param_one, c.param_two};
      rg0 = regrease_time;
      rk0 = rack_in_time;
      i_client.run(c);
      if (res == 1 && !c.param_one[9] && c.code == 16'd42120)
         exp_light = c.param_one[8];
      if (res == 1 && !c.param_one[9] && c.code == 16'd42376)
         exp_load = c.param_one[8];
      chk(cmd_done, 1, name);
      chk(32'(cmd_result), res, name);
      chk(light_on, exp_light, name);
      chk(load_on, exp_load, name);
      chk(regrease_time, (res == 1 && c.code == 16'd41353 && rg != '1) ? rg : rg0, name);
      if (res == 1 && c.code == 16'd41353 && c.rack != '1)
         chk(rack_in_time, c.rack, name);
      else
         chk(rack_in_time - rk0 <= 3, 1, name);
      $display("test %s done", name);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // about 660 cycles of traffic expected; this leaves wide margin
   initial begin
      #200_000;
      miscompares++;
      $display("[ERR] %0t watchdog expired", $time);
      end_of_test();
   end
   initial begin
      pocb_cmd_t c;
      logic [15:0] d, k;
      logic [31:0] v;
      int t;
      admin_pw = rnd();
      oper_pw = rnd();
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      cmd(mk(16'd41353, 16'd18, 16'h0, admin_pw, 16'h0967, 16'h5300, 32'd28944000), "max");
      v = rnd() % 32'd157766401;
      cmd(mk(16'd41353, 16'd18, 16'h0, oper_pw, v[31:16], v[15:0], '1), "keep rack");
      cmd(mk(16'd41353, 16'd18, 16'h0, admin_pw, '1, '1, 32'd0), "keep regrease");
      cmd(mk(16'd41353, 16'd18, 16'h0, admin_pw, 16'h0967, 16'h5301, 32'd5), "over");
      cmd(mk(16'd41353, 16'd18, 16'h0, admin_pw, 16'h0, 16'h7, 32'd28944001), "over");
      cmd(mk(16'd41353, 16'd16, 16'h0, admin_pw, 16'h0, 16'h7, 32'd9), "bad count");
      cmd(mk(16'd41353, 16'd18, 16'h0, oper_pw, '1, '1, '1), "keep both");
      for (int i = 0; i < 2; i++) begin
         k = i ? 16'd42376 : 16'd42120;
         v = rnd();
         cmd(mk(k, 16'd13, 16'h2001, admin_pw, {8'h01, v[7:0]}, v[15:0], v), "on");
         i_client.rd(i ? POCB_ADDR_LOAD_STATUS : POCB_ADDR_LIGHT_STATUS, d);
         chk(d[0], 1, "status on");
         cmd(mk(k, 16'd13, 16'h2002, admin_pw, 16'h0, 16'h0, 0), "bad dest");
         cmd(mk(k, 16'd13, 16'h2001, ~admin_pw, 16'h0, 16'h0, 0), "bad pw");
         c = mk(k, 16'd13, 16'h2001, oper_pw, 16'h0, 16'h0, 0);
         c.security = 16'h0002;
         cmd(c, "bad security");
         cmd(mk(k, 16'd13, 16'h2001, oper_pw, 16'h0200, 16'h0000, 0), "delay 0");
         cmd(mk(k, 16'd13, 16'h2001, oper_pw, 16'h02d2, 16'hf100, 0), "delay big");
         cmd(mk(k, 16'd13, 16'h2001, oper_pw, 16'h02d2, 16'hf001, 0), "tail");
         cmd(mk(k, 16'd13, 16'h2001, oper_pw, 16'h02d2, 16'hf000, 0), "delay max");
         i_client.rd(i ? POCB_ADDR_LOAD_STATUS : POCB_ADDR_LIGHT_STATUS, d);
         chk(d[2:0], 3'b011, "pending off");
         i_client.rd(i ? POCB_ADDR_LOAD_REMAIN : POCB_ADDR_LIGHT_REMAIN, d);
         chk(d >= 53998 && d <= 54000, 1, "remaining");
         cmd(mk(k, 16'd13, 16'h2001, admin_pw, 16'h0200, 16'h0200, 0), "delay 2");
         t = 0;
         while ((i ? load_on : light_on) === 1'b1 && t < 4 * CPS) begin
            @(negedge clk);
            t++;
         end
         chk(t >= CPS - 3 && t <= 2 * CPS + 2, 1, "delay span");
         exp_light = 0;
         exp_load = 0;
      end
      v = regrease_time;
      breaker_closed = 1'b1;
      repeat (5 * CPS) @(negedge clk);
      chk((regrease_time - v) inside {4, 5}, 1, "regrease runs");
      i_client.rd(16'h3000, d);
      chk(d, 0, "unmapped");
      i_client.rd(POCB_ADDR_CODE, d);
      chk(d, 0, "write only");
      end_of_test();
   end
endmodule
